// ### include/fh_codec_regs.svh
// Constants for the fronthaul IP/UDP and transport header codec.
// Assumes byte-wide streams in network order; included by bare name.
`ifndef FH_CODEC_REGS_SVH
`define FH_CODEC_REGS_SVH
`define ETYPE_IPV4 16'h0800
`define ETYPE_IPV6 16'h86DD
`define IPV4_VER_IHL 8'h45
`define IPV4_HDR_LEN 16'h0014
`define IPV6_HDR_LEN 16'h0028
`define UDP_HDR_LEN 16'h0008
`define PROTO_UDP 8'h11
`define NH_NO_NEXT 8'h3B
`define NH_HOP 8'h00
`define NH_ROUTE 8'h2B
`define NH_FRAG 8'h2C
`define NH_ESP 8'h32
`define NH_AUTH 8'h33
`define NH_DEST 8'h3C
`define NH_MOBILITY 8'h87
`define NH_HIP 8'h8B
`define NH_SHIM6 8'h8C
`define REVISION_ONE 4'h1
`define SPARE_ZERO 3'h0
`define KIND_IQ 8'h00
`define KIND_CTRL 8'h02
`define KIND_DELAY 8'h05
`define TRANSPORT_HDR_LEN 8
`define JUMBO_MAX 16'h2328
`define UDP_PORT_DEFAULT 16'hAEAE
`define TTL_DEFAULT 8'h40
`endif

// ### include/fh_codec_pkg.sv
// Types for the fronthaul header codec.
// Assumes the constants header is available on the include path.
package fh_codec_pkg;
    typedef struct packed {
        logic [3:0] protocol_revision;
        logic [2:0] header_spare_bits;
        logic chaining_flag;
        logic [7:0] message_kind;
        logic [15:0] payload_length;
        logic [15:0] antenna_carrier_flow_id;
        logic [15:0] sequence_field;
    } transport_hdr_t;

    typedef struct packed {
        logic ipv6;
        logic [31:0] src_v4;
        logic [31:0] dst_v4;
        logic [127:0] src_v6;
        logic [127:0] dst_v6;
        logic [15:0] src_port;
    } ip_cfg_t;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } byte_beat_t;

    typedef struct packed {
        logic [3:0] unit_port_subfield;
        logic [3:0] band_sector_subfield;
        logic [3:0] component_carrier_subfield;
        logic [3:0] radio_port_subfield;
    } flow_split_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_ETYPE = 3'b001,
        TX_IP = 3'b010,
        TX_UDP = 3'b011,
        TX_HDR = 3'b100,
        TX_BODY = 3'b101
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_ETYPE = 3'b000,
        RX_IP = 3'b001,
        RX_UDP = 3'b010,
        RX_HDR = 3'b011,
        RX_BODY = 3'b100,
        RX_DROP = 3'b101
    } rx_state_t;
endpackage

// ### logic/fh_udp_header_codec.sv
// Fronthaul IP/UDP encapsulation and 8-byte transport header codec.
// Assumes a MAC that supplies and accepts bytes from the Ethertype on,
// addresses already stripped, and a byte-wide application message stream.
`timescale 1ns/10ps
`include "fh_codec_regs.svh"

module fh_udp_header_codec (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Configuration
    input wire fh_codec_pkg::ip_cfg_t cfg,
    input wire logic [15:0] cfg_dst_port,
    input wire logic [3:0] cfg_split_w0,
    input wire logic [3:0] cfg_split_w1,
    input wire logic [3:0] cfg_split_w2,
    input wire logic cfg_peer_ipv4,
    input wire logic cfg_tx_csum_v4,
    input wire logic cfg_rx_csum_chk,
    // Egress message side
    input wire logic tx_start,
    input wire fh_codec_pkg::transport_hdr_t tx_hdr,
    input wire logic [7:0] tx_data,
    input wire logic tx_data_valid,
    output logic tx_ready,
    output logic tx_busy,
    // Egress link side
    output fh_codec_pkg::byte_beat_t link_tx,
    input wire logic link_tx_ready,
    // Ingress link side (from the MAC pins)
    input wire fh_codec_pkg::byte_beat_t link_rx,
    // Ingress message side
    output fh_codec_pkg::transport_hdr_t rx_hdr,
    output logic rx_hdr_valid,
    output fh_codec_pkg::flow_split_t rx_flow,
    output logic rx_kind_unknown,
    output fh_codec_pkg::byte_beat_t rx_out,
    output logic rx_drop_pulse,
    output logic rx_csum_bad,
    output logic arp_enable
);
    import fh_codec_pkg::*;

    // ----------------------------------------
    // Egress
    // ----------------------------------------
    tx_state_t tx_st, next_tx_st;
    logic [5:0] tx_idx, next_tx_idx;
    logic [15:0] tx_csum_v4, tx_csum_v6;
    logic [7:0] tx_byte;
    logic [15:0] udp_len, ip_len;
    logic [7:0] ip_b[40];
    logic [7:0] udp_b[8];
    logic [7:0] hdr_b[8];
    logic [16:0] ip_sum_a;
    logic [15:0] ip_sum;
    logic tx_last;

    assign udp_len = 16'(`UDP_HDR_LEN + `TRANSPORT_HDR_LEN + tx_hdr.payload_length);
    assign ip_len = 16'(`IPV4_HDR_LEN + udp_len);
    // IPv4 header sum precomputed from fixed fields; addresses folded in.
    always_comb begin
        logic [19:0] s;
        s = 20'({`IPV4_VER_IHL, 8'h00}) + 20'(ip_len) + 20'h0_4000
            + 20'({`TTL_DEFAULT, `PROTO_UDP}) + 20'(cfg.src_v4[31:16])
            + 20'(cfg.src_v4[15:0]) + 20'(cfg.dst_v4[31:16]) + 20'(cfg.dst_v4[15:0]);
        ip_sum_a = 17'(s[15:0]) + 17'(s[19:16]);
        ip_sum = ~(ip_sum_a[15:0] + 16'(ip_sum_a[16]));
    end

    always_comb begin
        for (int i = 0; i < 40; i++) begin
            ip_b[i] = 8'h00;
        end
        if (!cfg.ipv6) begin
            ip_b[0] = `IPV4_VER_IHL;
            ip_b[2] = ip_len[15:8];
            ip_b[3] = ip_len[7:0];
            ip_b[6] = 8'h40; // do-not-fragment, offset zero
            ip_b[8] = `TTL_DEFAULT;
            ip_b[9] = `PROTO_UDP;
            ip_b[10] = ip_sum[15:8];
            ip_b[11] = ip_sum[7:0];
            for (int i = 0; i < 4; i++) begin
                ip_b[12 + i] = cfg.src_v4[31 - 8 * i -: 8];
                ip_b[16 + i] = cfg.dst_v4[31 - 8 * i -: 8];
            end
        end else begin
            ip_b[0] = 8'h60;
            ip_b[4] = udp_len[15:8];
            ip_b[5] = udp_len[7:0];
            ip_b[6] = `PROTO_UDP; // upper layer directly, no extension
            ip_b[7] = `TTL_DEFAULT;
            for (int i = 0; i < 16; i++) begin
                ip_b[8 + i] = cfg.src_v6[127 - 8 * i -: 8];
                ip_b[24 + i] = cfg.dst_v6[127 - 8 * i -: 8];
            end
        end
        udp_b[0] = cfg.src_port[15:8];
        udp_b[1] = cfg.src_port[7:0];
        udp_b[2] = cfg_dst_port[15:8];
        udp_b[3] = cfg_dst_port[7:0];
        udp_b[4] = udp_len[15:8];
        udp_b[5] = udp_len[7:0];
        // IPv6 always carries the sum; IPv4 may send zero
        if (cfg.ipv6) begin
            udp_b[6] = tx_csum_v6[15:8];
            udp_b[7] = tx_csum_v6[7:0];
        end else if (cfg_tx_csum_v4 && tx_hdr.payload_length == 16'h0000) begin
            udp_b[6] = tx_csum_v4[15:8];
            udp_b[7] = tx_csum_v4[7:0];
        end else begin
            udp_b[6] = 8'h00; // body is not summed, so send the not-calculated mark
            udp_b[7] = 8'h00;
        end
        hdr_b[0] = {`REVISION_ONE, `SPARE_ZERO, tx_hdr.chaining_flag};
        hdr_b[1] = tx_hdr.message_kind;
        hdr_b[2] = tx_hdr.payload_length[15:8];
        hdr_b[3] = tx_hdr.payload_length[7:0];
        hdr_b[4] = tx_hdr.antenna_carrier_flow_id[15:8];
        hdr_b[5] = tx_hdr.antenna_carrier_flow_id[7:0];
        hdr_b[6] = tx_hdr.sequence_field[15:8];
        hdr_b[7] = tx_hdr.sequence_field[7:0];
    end

    // UDP checksum needs the whole payload up front; the caller supplies it
    // through the precomputed payload sum is not possible without buffering,
    // so the sum covers pseudo header, UDP header and transport header only
    // and body_sum is tied to zero; IPv4 sends it only for a zero-length body.
    logic [15:0] body_sum;
    assign body_sum = 16'h0000;
    always_comb begin
        logic [23:0] a;
        logic [23:0] b;
        logic [16:0] f;
        a = 24'(cfg.src_v4[31:16]) + 24'(cfg.src_v4[15:0]) + 24'(cfg.dst_v4[31:16])
            + 24'(cfg.dst_v4[15:0]) + 24'(`PROTO_UDP) + 24'(udp_len) + 24'(udp_len)
            + 24'(cfg.src_port) + 24'(cfg_dst_port) + 24'(body_sum);
        for (int i = 0; i < 4; i++) begin
            a = a + 24'({hdr_b[2 * i], hdr_b[2 * i + 1]});
        end
        b = a - 24'(cfg.src_v4[31:16]) - 24'(cfg.src_v4[15:0])
            - 24'(cfg.dst_v4[31:16]) - 24'(cfg.dst_v4[15:0]);
        for (int i = 0; i < 16; i++) begin
            b = b + 24'(cfg.src_v6[127 - 16 * (i % 8) -: 16] & {16{i < 8}})
                + 24'(cfg.dst_v6[127 - 16 * (i % 8) -: 16] & {16{i >= 8}});
        end
        f = 17'(a[15:0]) + 17'(a[23:16]);
        tx_csum_v4 = ~(f[15:0] + 16'(f[16]));
        f = 17'(b[15:0]) + 17'(b[23:16]);
        f = 17'(f[15:0]) + 17'(f[16]);
        tx_csum_v6 = (~f[15:0] == 16'h0000) ? 16'hFFFF : ~f[15:0];
    end

    logic [15:0] tx_body_cnt, next_tx_body_cnt;
    always_comb begin
        next_tx_st = tx_st;
        next_tx_idx = tx_idx;
        next_tx_body_cnt = tx_body_cnt;
        tx_byte = 8'h00;
        tx_last = 1'b0;
        tx_ready = 1'b0;
        case (tx_st)
            TX_IDLE: begin
                if (tx_start) begin
                    next_tx_st = TX_ETYPE;
                    next_tx_idx = 6'd0;
                end
            end
            TX_ETYPE: begin
                tx_byte = cfg.ipv6 ? (tx_idx[0] ? 8'hDD : 8'h86) : (tx_idx[0] ? 8'h00 : 8'h08);
            end
            TX_IP: tx_byte = ip_b[tx_idx];
            TX_UDP: tx_byte = udp_b[tx_idx[2:0]];
            TX_HDR: begin
                tx_byte = hdr_b[tx_idx[2:0]];
                tx_last = (tx_idx == 6'd7) && (tx_hdr.payload_length == 16'h0000);
            end
            TX_BODY: begin
                tx_byte = tx_data;
                tx_ready = link_tx_ready;
                tx_last = (tx_body_cnt == 16'h0001);
            end
            default: next_tx_st = TX_IDLE;
        endcase
        if (link_tx_ready && tx_st != TX_IDLE && (tx_st != TX_BODY || tx_data_valid)) begin
            next_tx_idx = 6'(tx_idx + 6'd1);
            case (tx_st)
                TX_ETYPE: if (tx_idx == 6'd1) begin
                    next_tx_st = TX_IP;
                    next_tx_idx = 6'd0;
                end
                TX_IP: if (tx_idx == (cfg.ipv6 ? 6'd39 : 6'd19)) begin
                    next_tx_st = TX_UDP;
                    next_tx_idx = 6'd0;
                end
                TX_UDP: if (tx_idx == 6'd7) begin
                    next_tx_st = TX_HDR;
                    next_tx_idx = 6'd0;
                end
                TX_HDR: if (tx_idx == 6'd7) begin
                    next_tx_st = tx_last ? TX_IDLE : TX_BODY;
                    next_tx_body_cnt = tx_hdr.payload_length;
                end
                TX_BODY: begin
                    next_tx_body_cnt = 16'(tx_body_cnt - 16'h0001);
                    if (tx_last) begin
                        next_tx_st = TX_IDLE;
                    end
                end
                default: next_tx_st = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st <= TX_IDLE;
            tx_idx <= 6'd0;
            tx_body_cnt <= 16'h0000;
        end else if (clk_en) begin
            tx_st <= next_tx_st;
            tx_idx <= next_tx_idx;
            tx_body_cnt <= next_tx_body_cnt;
        end
    end

    always_comb begin
        link_tx.valid = (tx_st != TX_IDLE) && (tx_st != TX_BODY || tx_data_valid);
        link_tx.last = tx_last;
        link_tx.data = tx_byte;
    end
    assign tx_busy = (tx_st != TX_IDLE);
    assign arp_enable = !cfg.ipv6 && cfg_peer_ipv4;

    // ----------------------------------------
    // Ingress
    // ----------------------------------------
    byte_beat_t rx_s1, rx_s2;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
        end else if (clk_en) begin
            rx_s1 <= link_rx;
            rx_s2 <= rx_s1;
        end
    end

    rx_state_t rx_st, next_rx_st;
    logic [5:0] rx_idx, next_rx_idx;
    logic rx_v6, next_rx_v6;
    logic [15:0] rx_etype, next_rx_etype;
    logic [15:0] rx_ucs, next_rx_ucs;
    logic [17:0] rx_sum, next_rx_sum;
    logic [13:0] rx_len, next_rx_len;
    logic [15:0] rx_body_cnt, next_rx_body_cnt;
    logic [63:0] rx_sh, next_rx_sh;
    transport_hdr_t next_rx_hdr;
    logic next_rx_hdr_valid, next_drop, next_csum_bad;
    byte_beat_t next_rx_out;
    logic bad_nh;
    logic [7:0] b;

    assign b = rx_s2.data;
    assign bad_nh = (b == `NH_HOP) || (b == `NH_ROUTE) || (b == `NH_FRAG) || (b == `NH_ESP)
        || (b == `NH_AUTH) || (b == `NH_DEST) || (b == `NH_MOBILITY) || (b == `NH_HIP)
        || (b == `NH_SHIM6) || (b == `NH_NO_NEXT);

    always_comb begin
        logic drop;
        drop = 1'b0;
        next_rx_st = rx_st;
        next_rx_idx = rx_idx;
        next_rx_v6 = rx_v6;
        next_rx_etype = rx_etype;
        next_rx_ucs = rx_ucs;
        next_rx_sum = rx_sum;
        next_rx_len = rx_len;
        next_rx_body_cnt = rx_body_cnt;
        next_rx_sh = rx_sh;
        next_rx_hdr = rx_hdr;
        next_rx_hdr_valid = 1'b0;
        next_drop = 1'b0;
        next_csum_bad = 1'b0;
        next_rx_out = '0;
        if (rx_s2.valid) begin
            next_rx_idx = 6'(rx_idx + 6'd1);
            next_rx_len = 14'(rx_len + 14'd1);
            if (rx_len == 14'(`JUMBO_MAX)) begin
                drop = 1'b1; // beyond jumbo size
            end
            case (rx_st)
                RX_ETYPE: begin
                    next_rx_etype = {rx_etype[7:0], b};
                    if (rx_idx == 6'd1) begin
                        next_rx_idx = 6'd0;
                        next_rx_sum = 18'h0_0000;
                        if ({rx_etype[7:0], b} == `ETYPE_IPV4) begin
                            next_rx_v6 = 1'b0;
                            next_rx_st = RX_IP;
                        end else if ({rx_etype[7:0], b} == `ETYPE_IPV6) begin
                            next_rx_v6 = 1'b1;
                            next_rx_st = RX_IP;
                        end else begin
                            drop = 1'b1;
                        end
                    end
                end
                RX_IP: begin
                    if (!rx_v6) begin
                        if (rx_idx == 6'd0 && b != `IPV4_VER_IHL) drop = 1'b1;
                        if (rx_idx == 6'd6 && (b[5] || b[4:0] != 5'h00)) drop = 1'b1;
                        if (rx_idx == 6'd7 && b != 8'h00) drop = 1'b1;
                        if (rx_idx == 6'd9 && b != `PROTO_UDP) drop = 1'b1;
                    end else begin
                        if (rx_idx == 6'd6 && bad_nh) drop = 1'b1;
                        if (rx_idx == 6'd6 && !bad_nh && b != `PROTO_UDP) drop = 1'b1;
                    end
                    if (rx_idx == (rx_v6 ? 6'd39 : 6'd19)) begin
                        next_rx_st = RX_UDP;
                        next_rx_idx = 6'd0;
                    end
                end
                RX_UDP: begin
                    next_rx_sh = {rx_sh[55:0], b};
                    if (rx_idx == 6'd3 && {rx_sh[7:0], b} != cfg_dst_port) drop = 1'b1;
                    if (rx_idx == 6'd7) begin
                        next_rx_ucs = {rx_sh[7:0], b};
                        next_rx_st = RX_HDR;
                        next_rx_idx = 6'd0;
                    end
                end
                RX_HDR: begin
                    next_rx_sh = {rx_sh[55:0], b};
                    next_rx_sum = 18'(rx_sum + (rx_idx[0] ? 18'(b) : 18'({b, 8'h00})));
                    if (rx_idx == 6'd7) begin
                        next_rx_hdr = {rx_sh[55:0], b};
                        next_rx_hdr_valid = 1'b1;
                        next_rx_body_cnt = {rx_sh[39:32], rx_sh[31:24]};
                        next_rx_st = RX_BODY;
                    end
                end
                RX_BODY: begin
                    next_rx_out.valid = (rx_body_cnt != 16'h0000); // padding stripped
                    next_rx_out.data = b;
                    next_rx_out.last = (rx_body_cnt == 16'h0001);
                    if (rx_body_cnt != 16'h0000) begin
                        next_rx_body_cnt = 16'(rx_body_cnt - 16'h0001);
                    end
                end
                RX_DROP: ;
                default: next_rx_st = RX_DROP;
            endcase
            if (drop) begin
                next_rx_st = RX_DROP;
                next_drop = 1'b1; // Silent: only a local event, nothing is sent
            end
            if (rx_s2.last) begin
                next_rx_st = RX_ETYPE;
                next_rx_idx = 6'd0;
                next_rx_len = 14'd0;
                // zero field means not calculated; only header part summed
                if (cfg_rx_csum_chk && rx_st == RX_BODY && rx_ucs != 16'h0000 && !rx_v6) begin
                    next_csum_bad = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st <= RX_ETYPE;
            rx_idx <= 6'd0;
            rx_v6 <= 1'b0;
            rx_etype <= 16'h0000;
            rx_ucs <= 16'h0000;
            rx_sum <= 18'h0_0000;
            rx_len <= 14'd0;
            rx_body_cnt <= 16'h0000;
            rx_sh <= 64'h0000_0000_0000_0000;
            rx_hdr <= '0;
            rx_hdr_valid <= 1'b0;
            rx_drop_pulse <= 1'b0;
            rx_csum_bad <= 1'b0;
            rx_out <= '0;
        end else if (clk_en) begin
            rx_st <= next_rx_st;
            rx_idx <= next_rx_idx;
            rx_v6 <= next_rx_v6;
            rx_etype <= next_rx_etype;
            rx_ucs <= next_rx_ucs;
            rx_sum <= next_rx_sum;
            rx_len <= next_rx_len;
            rx_body_cnt <= next_rx_body_cnt;
            rx_sh <= next_rx_sh;
            rx_hdr <= next_rx_hdr;
            rx_hdr_valid <= next_rx_hdr_valid;
            rx_drop_pulse <= next_drop;
            rx_csum_bad <= next_csum_bad;
            rx_out <= next_rx_out;
        end
    end

    // kind check and flow split from configured widths
    assign rx_kind_unknown = rx_hdr_valid && (rx_hdr.message_kind != `KIND_IQ)
        && (rx_hdr.message_kind != `KIND_CTRL) && (rx_hdr.message_kind != `KIND_DELAY);
    always_comb begin
        logic [15:0] id;
        logic [4:0] r;
        id = (rx_hdr.message_kind == `KIND_IQ || rx_hdr.message_kind == `KIND_CTRL)
            ? rx_hdr.antenna_carrier_flow_id : 16'h0000;
        r = 5'(5'd16 - 5'(cfg_split_w0) - 5'(cfg_split_w1) - 5'(cfg_split_w2));
        // unit port on top, radio port at bottom; each capped at 4 bits
        rx_flow.radio_port_subfield = 4'(id & ~(16'hFFFF << r));
        rx_flow.component_carrier_subfield = 4'((id >> r) & ~(16'hFFFF << cfg_split_w2));
        rx_flow.band_sector_subfield = 4'((id >> (r + 5'(cfg_split_w2)))
            & ~(16'hFFFF << cfg_split_w1));
        rx_flow.unit_port_subfield = 4'(id >> (r + 5'(cfg_split_w2) + 5'(cfg_split_w1)));
    end
endmodule

// ### tb/fh_codec_monitor.sv
// Checker on the codec top ports.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/10ps
module fh_codec_monitor (
    // Clock, reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Watched ports
    input wire fh_codec_pkg::ip_cfg_t cfg,
    input wire logic cfg_peer_ipv4,
    input wire logic tx_start,
    input wire logic tx_ready,
    input wire logic tx_busy,
    input wire fh_codec_pkg::byte_beat_t link_tx,
    input wire logic link_tx_ready,
    input wire fh_codec_pkg::transport_hdr_t rx_hdr,
    input wire logic rx_hdr_valid,
    input wire fh_codec_pkg::flow_split_t rx_flow,
    input wire logic rx_kind_unknown,
    input wire logic rx_drop_pulse,
    input wire logic arp_enable
);
    import fh_codec_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_arp_gate: assert property (arp_enable == (!cfg.ipv6 && cfg_peer_ipv4))
        else $error("arp gate wrong");
    a_start_etype: assert property (tx_start && !tx_busy |=> link_tx.valid
        && link_tx.data == (cfg.ipv6 ? 8'h86 : 8'h08)) else $error("bad first byte");
    a_stall_hold: assert property (link_tx.valid && !link_tx_ready |=> $stable(link_tx))
        else $error("byte moved in stall");
    a_ready_body: assert property (tx_ready |-> tx_busy && link_tx_ready)
        else $error("ready outside frame");
    a_valid_busy: assert property (link_tx.valid |-> tx_busy)
        else $error("byte while idle");
    a_drop_once: assert property (rx_drop_pulse |=> !rx_drop_pulse ##1 !rx_hdr_valid)
        else $error("drop pulse too long");
    a_kind_known: assert property (rx_hdr_valid |-> rx_kind_unknown ==
        !(rx_hdr.message_kind inside {8'h00, 8'h02, 8'h05})) else $error("kind flag");
    a_flow_scope: assert property (rx_hdr_valid &&
        !(rx_hdr.message_kind inside {8'h00, 8'h02}) |-> rx_flow == '0) else $error("flow");
endmodule

// ### tb/fh_peer_model.sv
// Link peer: takes egress bytes with random stalls.
// Assumes bytes count only on an edge with valid and ready.
`timescale 1ns/10ps
module fh_peer_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire fh_codec_pkg::byte_beat_t link_tx,
    output logic link_tx_ready
);
    logic [7:0] got [$];
    logic [3:0] s = 4'h5;
    initial link_tx_ready = 1'b0;
    // Stalls about a fifth of cycles so held bytes get exercised
    always @(negedge mclk) begin
        s <= {s[2:0], s[3] ^ s[2]};
        link_tx_ready <= s[0] | s[1];
    end
    always @(posedge mclk)
        if (!sys_rst && link_tx.valid && link_tx_ready) got.push_back(link_tx.data);
endmodule

// ### tb/fh_udp_header_codec_bench.sv
// Self-checking bench for the header codec with a link peer.
// Assumes package and constants header compiled first.
`timescale 1ns/10ps
module fh_udp_header_codec_bench;
    import fh_codec_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, tx_start = 1'b0, tx_data_valid = 1'b0, uk;
    logic cfg_peer_ipv4 = 1'b0, cfg_rx_csum_chk = 1'b0, tx_ready, tx_busy, link_tx_ready;
    logic rx_hdr_valid, rx_kind_unknown, rx_drop_pulse, arp_enable, cfg_tx_csum_v4 = 1'b0;
    logic [31:0] ob;
    logic [15:0] cfg_dst_port = 16'hAEAE;
    logic [7:0] tx_data = 8'h00, body [16], q [$];
    logic [1:0] k = 2'h0;
    logic [31:0] rs = 32'h114b_075e;
    int fail_count = 0, comparisons = 0, hv, dv, ov, bi;
    ip_cfg_t cfg = '0;
    transport_hdr_t tx_hdr = '0, rx_hdr, hs;
    byte_beat_t link_tx, rx_out, link_rx = '0;
    flow_split_t rx_flow, fs;
    fh_udp_header_codec DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .cfg(cfg),
        .cfg_dst_port(cfg_dst_port), .cfg_split_w0(4'h4), .cfg_split_w1(4'h4),
        .cfg_split_w2(4'h4), .cfg_peer_ipv4(cfg_peer_ipv4), .cfg_tx_csum_v4(cfg_tx_csum_v4),
        .cfg_rx_csum_chk(cfg_rx_csum_chk), .tx_start(tx_start), .tx_hdr(tx_hdr),
        .tx_data(tx_data), .tx_data_valid(tx_data_valid), .tx_ready(tx_ready),
        .tx_busy(tx_busy), .link_tx(link_tx), .link_tx_ready(link_tx_ready),
        .link_rx(link_rx), .rx_hdr(rx_hdr), .rx_hdr_valid(rx_hdr_valid), .rx_flow(rx_flow),
        .rx_kind_unknown(rx_kind_unknown), .rx_out(rx_out), .rx_drop_pulse(rx_drop_pulse),
        .rx_csum_bad(), .arp_enable(arp_enable));
    fh_peer_model peer (.mclk(mclk), .sys_rst(sys_rst), .link_tx(link_tx),
        .link_tx_ready(link_tx_ready));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) if (tx_ready && tx_data_valid) bi <= bi + 1;
    always @(negedge mclk) begin
        k <= k + 2'h1;
        if (tx_ready || !tx_data_valid) tx_data_valid <= k != 2'h3;
        tx_data <= body[bi[3:0]];
        if (rx_hdr_valid) begin
            hv++;
            hs = rx_hdr;
            uk = rx_kind_unknown;
            fs = rx_flow;
        end
        dv += rx_drop_pulse;
        ov += rx_out.valid;
        if (rx_out.valid) ob = {ob[23:0], rx_out.data};
    end
    function automatic logic [31:0] nx(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(string n, logic [63:0] e, logic [63:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_for(int n);
        if (n > 300) begin
            fail_count++;
            finish_test();
        end
        @(negedge mclk);
    endtask
    task automatic egress(logic v6, logic [7:0] kind, int pl);
        int u = v6 ? 42 : 22, n = 0;
        logic [63:0] h;
        rs = nx(rs);
        cfg.ipv6 = v6;
        cfg_peer_ipv4 = rs[3];
        cfg_tx_csum_v4 = rs[4];
        tx_hdr = {rs[7:1], rs[0], kind, pl[15:0], rs};
        peer.got.delete();
        bi = 0;
        tx_start = 1'b1;
        @(negedge mclk);
        tx_start = 1'b0;
        while (peer.got.size() < u + 16 + pl) wait_for(n++);
        repeat (2) @(negedge mclk);
        chk("ethertype", v6 ? 16'h86DD : 16'h0800, {peer.got[0], peer.got[1]});
        if (v6) begin
            chk("next header", 8'h11, peer.got[8]);
            chk("udp sum zero", 0, {peer.got[48], peer.got[49]} == 16'h0000);
        end else begin
            chk("ver ihl", 8'h45, peer.got[2]);
            chk("fragment", 0, {peer.got[8], peer.got[9]} & 16'h3FFF);
            chk("udp sum", 0, {peer.got[28], peer.got[29]});
        end
        chk("dst port", cfg_dst_port, {peer.got[u + 2], peer.got[u + 3]});
        chk("udp length", 16 + pl, {peer.got[u + 4], peer.got[u + 5]});
        for (int i = 0; i < 8; i++) h = {h[55:0], peer.got[u + 8 + i]};
        chk("header", {4'h1, 3'h0, tx_hdr[56:0]}, h);
        for (int i = 0; i < pl; i++) chk("body", body[i], peer.got[u + 16 + i]);
    endtask
    task automatic ingress(logic v6, logic [7:0] b, logic [15:0] fr, logic [7:0] kind, logic dr);
        int t = {b, 8'h00} + 40 + fr + 16'h4011, n = 0;
        transport_hdr_t h;
        rs = nx(rs);
        h = {4'h1, 3'h0, 1'b0, kind, 16'h0004, rs};
        t = (t & 16'hFFFF) + (t >> 16);
        if (v6) q = '{8'h86, 8'hDD, 8'h60, 0, 0, 0, 0, 8'd20, b, 8'h40};
        else q = '{8'h08, 0, b, 0, 0, 8'd40, 0, 0, fr[15:8], fr[7:0], 8'h40, 8'h11,
            ~t[15:8], ~t[7:0]};
        repeat (v6 ? 32 : 8) q.push_back(8'h00);
        q = {q, rs[7:0], rs[15:8], cfg_dst_port[15:8], cfg_dst_port[7:0], 8'h00, 8'd20, 8'h00,
            8'h00, h[63:56], h[55:48], h[47:40], h[39:32], h[31:24], h[23:16], h[15:8], h[7:0],
            rs[31:24], rs[23:16], rs[7:0], rs[15:8]};
        hv = 0;
        dv = 0;
        ov = 0;
        foreach (q[i]) begin
            link_rx = {1'b1, i == q.size() - 1, q[i]};
            @(negedge mclk);
        end
        link_rx = {2'b00, ~q[$]};
        while (dr ? dv == 0 : ov < 4) wait_for(n++);
        repeat (4) @(negedge mclk);
        chk("drops", dr, dv);
        chk("headers", !dr, hv);
        if (!dr) begin
            chk("rx header", h, hs);
            chk("unknown", !(kind inside {8'h00, 8'h02, 8'h05}), uk);
            chk("flow", kind inside {8'h00, 8'h02} ? h[31:16] : 16'h0, fs);
            chk("body beats", 4, ov);
            chk("body data", {rs[31:16], rs[7:0], rs[15:8]}, ob);
        end
    endtask
    initial begin
        for (int i = 0; i < 16; i++) begin
            rs = nx(rs);
            body[i] = rs[7:0];
        end
        cfg.src_port = rs[15:0];
        cfg_dst_port = {rs[31:17], 1'b1};
        cfg_rx_csum_chk = rs[5];
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) egress(i[0], i % 3 == 0 ? 8'h00 : i % 3 == 1 ? 8'h02 : 8'h05,
            i + 1);
        ingress(0, 8'h45, 16'h4000, 8'h00, 0);
        ingress(0, 8'h45, 16'h0000, 8'h05, 0);
        ingress(1, 8'h11, 16'h0000, 8'h02, 0);
        ingress(0, 8'h45, 16'h0000, 8'h07, 0);
        ingress(0, 8'h46, 16'h0000, 8'h00, 1);
        ingress(0, 8'h45, 16'h2000, 8'h02, 1);
        ingress(0, 8'h45, 16'h0001, 8'h00, 1);
        ingress(1, 8'h3B, 16'h0000, 8'h00, 1);
        ingress(1, 8'h2C, 16'h0000, 8'h02, 1);
        finish_test();
    end
endmodule
bind fh_udp_header_codec fh_codec_monitor MON (.mclk(mclk), .sys_rst(sys_rst), .cfg(cfg),
    .cfg_peer_ipv4(cfg_peer_ipv4), .tx_start(tx_start), .tx_ready(tx_ready),
    .tx_busy(tx_busy), .link_tx(link_tx), .link_tx_ready(link_tx_ready), .rx_hdr(rx_hdr),
    .rx_hdr_valid(rx_hdr_valid), .rx_flow(rx_flow), .rx_kind_unknown(rx_kind_unknown),
    .rx_drop_pulse(rx_drop_pulse), .arp_enable(arp_enable));
